// ===== pkg/lnb_i2c_defs.svh
// Shared constants of the antenna supply two-wire slave
`ifndef LNB_I2C_DEFS_SVH
`define LNB_I2C_DEFS_SVH

// Register addresses inside the device
`define REG_STATUS 8'h00
`define REG_CONFIG 8'h01

// Reset values
`define CONFIG_RESET 8'h00
`define STATUS_RESET 8'h00

// Byte and field layout
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define DIAG_BITS 5
`define RW_BIT 0

// Buffer shape between the link and the core
`define BUF_DEPTH 2

`endif

// ===== pkg/lnb_i2c_pkg.sv
// Types of the antenna supply two-wire slave
package lnb_i2c_pkg;

   // Link engine states
   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_ack,
      st_tx,
      st_ackin,
      st_ignore
   } link_state_t;

   // Position of the byte within a transfer
   typedef logic [1:0] byte_pos_t;

endpackage

// ===== tb/i2c_master_model.sv
// Two-wire bus master model driving the slave's link pins
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic link_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // Bus idles released, both lines high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Quarter bit, eight link periods
   task automatic hp();
      repeat (8) @(negedge link_clk);
   endtask
   // Data falls while clock high
   task automatic start();
      sda_low = 1'b0;
      scl = 1'b1;
      hp();
      sda_low = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask
   // Data rises while clock high, closing each frame
   task automatic stop();
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
   endtask
   // One bit: set in clock low, sampled mid clock high
   task automatic bit1(input logic tx, output logic rx);
      sda_low = !tx;
      hp();
      scl = 1'b1;
      hp();
      rx = sda;
      hp();
      scl = 1'b0;
      hp();
   endtask
   // Byte plus ninth clock; all ones releases the line for reading
   task automatic xfer(input logic [7:0] d, input logic a_tx, output logic [7:0] q,
      output logic a_rx);
      for (int i = 7; i >= 0; i--) begin
         bit1(d[i], q[i]);
      end
      bit1(a_tx, a_rx);
   endtask
endmodule

// ===== tb/lnb_supply_i2c_slave_sva.sv
// Port checker of the antenna supply two-wire slave
`timescale 1ns/1ps
module lnb_supply_i2c_slave_sva (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_sel,
   input wire logic uvlo,
   input wire logic [4:0] diag,
   input wire logic [7:0] cfg,
   input wire logic [7:0] wr_data,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire lnb_i2c_pkg::link_state_t link_state
);
   import lnb_i2c_pkg::*;
   // Core side: reset, buffer and config register
   a_reset_clear: assert property (@(posedge clk) !reset_n |=> cfg == 8'h00 && !wr_valid)
      else $error("reset did not clear config");
   a_wr_hold: assert property (@(posedge clk) disable iff (!reset_n)
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
      else $error("stalled byte lost");
   a_cfg_take: assert property (@(posedge clk) disable iff (!reset_n)
      wr_valid && wr_ready |=> cfg == $past(wr_data))
      else $error("config missed taken byte");
   a_cfg_keep: assert property (@(posedge clk) disable iff (!reset_n)
      !(wr_valid && wr_ready) |=> $stable(cfg))
      else $error("config changed without handshake");
   // Link side: data line driving and framing
   a_out_zero: assert property (@(posedge link_clk) disable iff (!reset_n) sda_out == 1'b0)
      else $error("data line driven high");
   a_oe_lowclk: assert property (@(posedge link_clk) disable iff (!reset_n)
      $rose(sda_oe) |-> !scl_in)
      else $error("pull started in clock high");
   a_oe_steady: assert property (@(posedge link_clk) disable iff (!reset_n)
      scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data moved in clock high");
   a_uvlo_mute: assert property (@(posedge link_clk) disable iff (!reset_n)
      uvlo [*8] |-> !sda_oe || link_state == st_tx)
      else $error("acknowledge under lockout");
   a_idle_free: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_state == st_idle |-> !sda_oe)
      else $error("idle engine holds data line");
   a_start_seen: assert property (@(posedge link_clk) disable iff (!reset_n)
      scl_in && $fell(sda_in) |-> ##[1:8] link_state == st_rx)
      else $error("start not taken");
   a_stop_idle: assert property (@(posedge link_clk) disable iff (!reset_n)
      scl_in && $rose(sda_in) |-> ##[1:8] link_state == st_idle)
      else $error("stop did not idle engine");
   // Main scenarios reached
   c_take: cover property (@(posedge clk) wr_valid && wr_ready);
   c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
   c_send: cover property (@(posedge link_clk) link_state == st_tx);
endmodule
bind lnb_supply_i2c_slave lnb_supply_i2c_slave_sva chk (.clk(clk), .reset_n(reset_n),
   .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .addr_sel(addr_sel), .uvlo(uvlo), .diag(diag), .cfg(cfg), .wr_data(wr_data),
   .wr_valid(wr_valid), .wr_ready(wr_ready), .link_state(link_state));

// ===== tb/lnb_supply_i2c_slave_tb.sv
// Self-checking bench of the antenna supply two-wire slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module lnb_supply_i2c_slave_tb;
   import lnb_i2c_pkg::*;
   logic clk, link_clk, reset_n, addr_sel, uvlo, wr_ready, sda_out, sda_oe, wr_valid;
   logic scl, m_low, a;
   logic [4:0] diag;
   logic [7:0] cfg, wr_data, q;
   link_state_t link_state;
   int err_count = 0;
   int checks_done = 0;
   // Pulled-up wire, low when either party pulls
   wire sda = !(m_low || (sda_oe && !sda_out));
   lnb_supply_i2c_slave dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .uvlo(uvlo),
      .diag(diag), .cfg(cfg), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .link_state(link_state));
   i2c_master_model m (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(m_low));
   // Core clock 4 ns, link clock 32 ns with its own phase
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #5;
      forever #16 link_clk = ~link_clk;
   end
   // Closing report
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Byte out, ninth clock level compared
   task automatic put(input logic [7:0] d, input logic e);
      m.xfer(d, 1'b1, q, a);
      `CHK("ack", e, a)
   endtask
   // Bounded wait for a buffered byte, looked at away from the launching edge
   task automatic wait_valid();
      for (int i = 0; i < 400 && wr_valid !== 1'b1; i++) @(negedge clk);
      if (wr_valid !== 1'b1) begin
         err_count++;
         give_verdict();
      end
   endtask
   // Two framed writes held while the user stalls, then drained in order
   // The pointer moves past config after each byte, so each write is its own frame
   task automatic t_write_stall();
      m.start();
      put(8'h10, 1'b0);
      put(8'h01, 1'b0);
      put(8'h11, 1'b0);
      m.stop();
      m.start();
      put(8'h10, 1'b0);
      put(8'h01, 1'b0);
      put(8'h22, 1'b0);
      m.stop();
      wait_valid();
      `CHK("wr_data", 8'h11, wr_data)
      `CHK("cfg", 8'h00, cfg)
      @(negedge clk) wr_ready = 1'b1;
      @(negedge clk) wr_ready = 1'b0;
      wait_valid();
      `CHK("wr_data", 8'h22, wr_data)
      `CHK("cfg", 8'h11, cfg)
      @(negedge clk) wr_ready = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("cfg", 8'h22, cfg)
      `CHK("wr_valid", 1'b0, wr_valid)
   endtask
   // Status then config streamed, ended by a high acknowledge
   task automatic t_read();
      m.start();
      put(8'h10, 1'b0);
      put(8'h00, 1'b0);
      m.stop();
      m.start();
      put(8'h11, 1'b0);
      m.xfer(8'hFF, 1'b0, q, a);
      `CHK("status", {3'b000, 5'h15}, q)
      m.xfer(8'hFF, 1'b1, q, a);
      `CHK("config", 8'h22, q)
      m.stop();
      `CHK("state", st_idle, link_state)
   endtask
   // Select pin moves the answering address
   task automatic t_select();
      @(negedge clk) addr_sel = 1'b1;
      m.start();
      put(8'h10, 1'b1);
      m.stop();
      m.start();
      put(8'h12, 1'b0);
      m.stop();
      @(negedge clk) addr_sel = 1'b0;
   endtask
   // Lockout mutes, status writes dropped, unchecked write lands
   task automatic t_uvlo_noack();
      @(negedge clk) uvlo = 1'b1;
      m.start();
      put(8'h10, 1'b1);
      m.stop();
      @(negedge clk) uvlo = 1'b0;
      m.start();
      put(8'h10, 1'b0);
      put(8'h00, 1'b0);
      put(8'h5A, 1'b0);
      m.stop();
      repeat (100) @(posedge clk);
      `CHK("cfg", 8'h22, cfg)
      m.start();
      m.xfer(8'h10, 1'b1, q, a);
      m.xfer(8'h01, 1'b1, q, a);
      m.xfer(8'h0C, 1'b1, q, a);
      m.stop();
      for (int i = 0; i < 400 && cfg !== 8'h0C; i++) @(negedge clk);
      `CHK("cfg", 8'h0C, cfg)
   endtask
   // Main sequence
   initial begin
      reset_n = 1'b0;
      addr_sel = 1'b0;
      uvlo = 1'b0;
      wr_ready = 1'b0;
      diag = 5'h15;
      repeat (40) @(negedge clk);
      `CHK("sda_oe", 1'b0, sda_oe)
      `CHK("state", st_idle, link_state)
      `CHK("cfg", 8'h00, cfg)
      reset_n = 1'b1;
      repeat (8) @(posedge link_clk);
      t_write_stall();
      t_read();
      t_select();
      t_uvlo_noack();
      give_verdict();
   end
   // Hang guard
   initial begin
      #400000;
      err_count++;
      give_verdict();
   end
endmodule

// ===== verilog/lnb_supply_i2c_slave.sv
// Two-wire serial slave of the antenna supply controller
//
// Contract
// - Data stable while clock high
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Bytes are eight bits, MSB first
// - Ninth clock carries the acknowledge
// - Device holds data low through acknowledge
// - Addressed device acknowledges every byte; a data byte that arrives while the core is still busy gets no acknowledge
// - No acknowledge during supply undervoltage lockout
// - Write: address, register, data; only config
// - Address 0 status, address 1 config
// - Read streams bytes until master withholds acknowledge
// - Select pin picks one of two addresses
`timescale 1ns/1ps
`include "lnb_i2c_defs.svh"
module lnb_supply_i2c_slave #(
   parameter logic [6:0] CHIP_ADDR_LO = 7'h08,  // Address with select pin low
   parameter logic [6:0] CHIP_ADDR_HI = 7'h09   // Address with select pin high
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel,
   input wire logic uvlo,
   input wire logic [`DIAG_BITS-1:0] diag,
   output logic [7:0] cfg,
   output logic [7:0] wr_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output lnb_i2c_pkg::link_state_t link_state
);
   import lnb_i2c_pkg::*;

   // ---------------- Link domain ----------------
   logic [1:0] lrst_q;  // Reset carried into the link domain
   logic link_reset_n;
   logic [3:0] pin_raw;  // scl, sda, select, lockout
   logic [3:0] pin_f1;
   logic [3:0] pin_f2;
   logic [3:0] pin_f3;
   logic [3:0] pin_q;  // Filtered pin levels
   logic scl_d;  // Previous filtered clock
   logic sda_d;  // Previous filtered data
   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;
   logic [1:0] ack_tog_s;  // Core acknowledge toggle, synchronised
   logic busy;  // A written byte still in flight

   link_state_t state;
   link_state_t next_state;
   logic [3:0] cnt;  // Bits in the current byte
   logic [3:0] next_cnt;
   logic [7:0] sh;  // Shift register
   logic [7:0] next_sh;
   logic is_read;  // Direction of the transfer
   logic next_is_read;
   byte_pos_t pos;  // Byte position, saturating
   byte_pos_t next_pos;
   logic [7:0] ptr;  // Register pointer
   logic [7:0] next_ptr;
   logic oe;  // Pulling data low
   logic next_oe;
   logic [7:0] wr_word;  // Byte handed to the core
   logic [7:0] next_wr_word;
   logic wr_tog;  // Flips on each handed byte
   logic next_wr_tog;
   logic read_req;  // Asks the core to freeze the read snapshot

   // ---------------- Core domain ----------------
   logic [1:0] wr_tog_s;  // Link toggle, synchronised
   logic [1:0] req_s;  // Snapshot request, synchronised
   logic tog_seen;  // Last toggle taken into the buffer
   logic next_tog_seen;
   logic [`DIAG_BITS-1:0] dg1;
   logic [`DIAG_BITS-1:0] dg2;
   logic [`DIAG_BITS-1:0] dg3;
   logic [`DIAG_BITS-1:0] diag_q;  // Filtered diagnostic levels
   logic [`DIAG_BITS-1:0] next_diag_q;
   logic [7:0] snap_status;  // Read snapshot, stable while requested
   logic [7:0] snap_cfg;
   logic [7:0] next_snap_status;
   logic [7:0] next_snap_cfg;
   logic [7:0] next_cfg;
   logic buf_in_ready;

   // Open-drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = oe;
   assign link_state = state;

   // Reset synchroniser into the link domain
   always_ff @(posedge link_clk) begin
      lrst_q <= {lrst_q[0], reset_n};
   end
   assign link_reset_n = lrst_q[1];

   // Three-flop pin filter; level moves once the last two agree
   assign pin_raw = {uvlo, addr_sel, sda_in, scl_in};
   generate
      for (genvar i = 0; i < 4; i++) begin : g_pin
         always_ff @(posedge link_clk) begin
            pin_f1[i] <= pin_raw[i];
            pin_f2[i] <= pin_f1[i];
            pin_f3[i] <= pin_f2[i];
            if (!link_reset_n) begin
               pin_q[i] <= 1'b1;
            end else if (pin_f2[i] == pin_f3[i]) begin
               pin_q[i] <= pin_f3[i];
            end
         end
      end
   endgenerate

   // Bus condition decode
   assign start_ev = pin_q[0] & scl_d & sda_d & ~pin_q[1];
   assign stop_ev = pin_q[0] & scl_d & ~sda_d & pin_q[1];
   assign scl_rise = pin_q[0] & ~scl_d;
   assign scl_fall = ~pin_q[0] & scl_d;
   assign busy = wr_tog ^ ack_tog_s[1];
   assign read_req = is_read & (state != st_idle);

   // Read byte selected by the pointer
   function automatic logic [7:0] read_byte(input logic [7:0] p, input logic [7:0] s,
                                            input logic [7:0] c);
      read_byte = (p == `REG_STATUS) ? s : ((p == `REG_CONFIG) ? c : 8'h00);
   endfunction

   // Link engine next state
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_is_read = is_read;
      next_pos = pos;
      next_ptr = ptr;
      next_oe = oe;
      next_wr_word = wr_word;
      next_wr_tog = wr_tog;
      if (stop_ev) begin
         // Release and idle
         next_state = st_idle;
         next_oe = 1'b0;
      end else if (start_ev) begin
         // Any start opens a fresh address byte
         next_state = st_rx;
         next_cnt = 4'h0;
         next_pos = 2'd0;
         next_is_read = 1'b0;
         next_oe = 1'b0;
      end else begin
         case (state)
            st_rx: begin
               if (scl_rise && cnt != `BYTE_BITS) begin
                  // Shift in, MSB first
                  next_sh = {sh[6:0], pin_q[1]};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == `BYTE_BITS) begin
                  // Ninth clock decision
                  next_state = st_ack;
                  next_oe = 1'b1;
                  if (pin_q[3]) begin
                     next_state = st_ignore;
                     next_oe = 1'b0;
                  end else if (pos == 2'd0) begin
                     if (sh[7:1] != (pin_q[2] ? CHIP_ADDR_HI : CHIP_ADDR_LO)) begin
                        next_state = st_ignore;
                        next_oe = 1'b0;
                     end
                     next_is_read = sh[`RW_BIT];
                  end else if (pos == 2'd1) begin
                     next_ptr = sh;
                  end else if (busy) begin
                     // Core not ready: refuse the byte
                     next_state = st_ignore;
                     next_oe = 1'b0;
                  end else begin
                     if (ptr == `REG_CONFIG) begin
                        next_wr_word = sh;
                        next_wr_tog = ~wr_tog;
                     end
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            st_ack, st_ackin: begin
               if (state == st_ackin && scl_rise && pin_q[1]) begin
                  // Master ends the read
                  next_state = st_ignore;
               end else if (scl_fall) begin
                  next_cnt = 4'h0;
                  next_pos = (pos == 2'd2) ? pos : pos + 2'd1;
                  if (is_read) begin
                     // Load and drive the first bit
                     next_sh = read_byte(ptr, snap_status, snap_cfg);
                     next_oe = ~next_sh[7];
                     next_ptr = ptr + 8'h01;
                     next_state = st_tx;
                  end else begin
                     next_oe = 1'b0;
                     next_state = st_rx;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (cnt == `LAST_BIT) begin
                     // Release for the master's acknowledge
                     next_oe = 1'b0;
                     next_state = st_ackin;
                  end else begin
                     next_sh = {sh[6:0], 1'b0};
                     next_oe = ~sh[6];
                     next_cnt = cnt + 4'h1;
                  end
               end
            end
            st_ignore: begin
               next_oe = 1'b0;
            end
            default: begin
               next_oe = 1'b0;
            end
         endcase
      end
   end

   // Link engine registers
   always_ff @(posedge link_clk) begin
      ack_tog_s <= {ack_tog_s[0], tog_seen};
      if (!link_reset_n) begin
         state <= st_idle;
         cnt <= 4'h0;
         sh <= 8'h00;
         is_read <= 1'b0;
         pos <= 2'd0;
         ptr <= `REG_STATUS;
         oe <= 1'b0;
         wr_word <= 8'h00;
         wr_tog <= 1'b0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         is_read <= next_is_read;
         pos <= next_pos;
         ptr <= next_ptr;
         oe <= next_oe;
         wr_word <= next_wr_word;
         wr_tog <= next_wr_tog;
         scl_d <= pin_q[0];
         sda_d <= pin_q[1];
      end
   end

   // Core side: crossing and diagnostic pin filter
   always_ff @(posedge clk) begin
      wr_tog_s <= {wr_tog_s[0], wr_tog};
      req_s <= {req_s[0], read_req};
      dg1 <= diag;
      dg2 <= dg1;
      dg3 <= dg2;
   end

   // Buffer between the handed byte and the user stream
   pair_buffer #(
      .WIDTH(8),
      .DEPTH(`BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(wr_word),
      .in_valid(wr_tog_s[1] ^ tog_seen),
      .in_ready(buf_in_ready),
      .out_data(wr_data),
      .out_valid(wr_valid),
      .out_ready(wr_ready)
   );

   // Core next values
   always_comb begin
      next_tog_seen = tog_seen;
      next_diag_q = (diag_q & ~(dg2 ^ dg3)) | (dg3 & ~(dg2 ^ dg3));
      next_snap_status = snap_status;
      next_snap_cfg = snap_cfg;
      next_cfg = cfg;
      if ((wr_tog_s[1] ^ tog_seen) && buf_in_ready) begin
         next_tog_seen = wr_tog_s[1];
      end
      if (wr_valid && wr_ready) begin
         // Drained byte becomes the config
         next_cfg = wr_data;
      end
      if (!req_s[1]) begin
         // Track live values while no read runs
         next_snap_status = {{(8-`DIAG_BITS){1'b0}}, diag_q};
         next_snap_cfg = cfg;
      end
   end

   // Core registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tog_seen <= 1'b0;
         diag_q <= '0;
         snap_status <= `STATUS_RESET;
         snap_cfg <= `CONFIG_RESET;
         cfg <= `CONFIG_RESET;
      end else begin
         tog_seen <= next_tog_seen;
         diag_q <= next_diag_q;
         snap_status <= next_snap_status;
         snap_cfg <= next_snap_cfg;
         cfg <= next_cfg;
      end
   end

endmodule

// ===== verilog/pair_buffer.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];  // Storage entries
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [PW-1:0] wr_ptr;  // Next entry to fill
   logic [PW-1:0] next_wr_ptr;
   logic [PW-1:0] rd_ptr;  // Oldest entry
   logic [PW-1:0] next_rd_ptr;
   logic [PW:0] count;  // Entries held
   logic [PW:0] next_count;
   logic push;
   logic pop;

   // Honest full and empty
   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Next pointers, count and contents
   always_comb begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         mem <= next_mem;
      end
   end

endmodule
